// [design/fbr_pkg.sv]
// How it works
// - two 512-byte sectors hold the variables; one bank always holds the full set
// - update erases destination sector first when the destination bank starts that sector, then programs unchanged words plus new value
// - while an update runs, reads are held off until it completes
// - flash programmed one 16-bit word per operation, erased only as a whole sector
// - no array fetch while a program or erase operation is active
// - bank size is a power of two, holds all variables, divides the sector
// - several banks per sector only because the variable set is under half a sector
// - flash op clock is the oscillator through a prescaler, 150 to 200 kHz
// - word program lasts nine op clock periods plus twenty-five bus clocks
// - an update programs the whole destination bank word by word
// - sector erase lasts four thousand op clock periods
// - bank status word is programmed last and marks the newest bank
// - at start the newest valid bank becomes current; invalid banks are erased later
package fbr_pkg;
	// ----------------------------------------
	// array geometry
	// ----------------------------------------
	localparam int SECTOR_BYTES = 512;
	localparam int NUM_SECTORS = 2;
	localparam int BANK_BYTES = 128;
	localparam int WORD_BYTES = 2;
	localparam int DW = 16;
	localparam int AW = 9;
	localparam int BW = 3;
	localparam int IW = 6;
	localparam int SW = 8;
	localparam int BANK_WORDS = BANK_BYTES / WORD_BYTES;
	localparam int SECTOR_WORDS = SECTOR_BYTES / WORD_BYTES;
	localparam int MEM_WORDS = SECTOR_WORDS * NUM_SECTORS;
	localparam int NUM_BANKS = MEM_WORDS / BANK_WORDS;
	localparam logic [IW-1:0] STATUS_IDX = 6'h3F;
	localparam logic [IW-1:0] FIRST_IDX = 6'h00;
	localparam logic [1:0] FIRST_IN_SECTOR = 2'h0;
	localparam logic [BW-1:0] FIRST_BANK = 3'h0;
	localparam logic [BW-1:0] LAST_BANK = 3'h7;
	localparam logic [DW-1:0] BLANK = 16'hFFFF;
	localparam logic [DW-1:0] SEQ_ZERO = 16'h0000;
	localparam logic [DW-1:0] SEQ_STEP = 16'h0001;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int SYS_CLK_HZ = 25_000_000;
	localparam int OP_CLK_MIN_HZ = 150_000;
	localparam int OP_CLK_MAX_HZ = 200_000;
	localparam int PRESCALE = (SYS_CLK_HZ + OP_CLK_MAX_HZ - 1) / OP_CLK_MAX_HZ;
	localparam int PW = 8;
	localparam logic [PW-1:0] PRESC_LAST = PW'(PRESCALE - 1);
	localparam logic [PW-1:0] PRESC_ZERO = 8'h00;
	localparam int CW = 12;
	localparam logic [CW-1:0] CNT_ZERO = 12'h000;
	localparam logic [CW-1:0] CNT_STEP = 12'h001;
	localparam int PROG_OP_TICKS = 9;
	localparam int PROG_BUS_CYCLES = 25;
	localparam int ERASE_OP_TICKS = 4000;
	localparam logic [CW-1:0] PROG_TICK_LAST = CW'(PROG_OP_TICKS - 1);
	localparam logic [CW-1:0] PROG_BUS_LAST = CW'(PROG_BUS_CYCLES - 1);
	// ----------------------------------------
	// controller states
	// ----------------------------------------
	typedef enum logic [8:0] {
		S_SCAN = 9'h001,
		S_SCHK = 9'h002,
		S_IDLE = 9'h004,
		S_RDATA = 9'h008,
		S_ERASE = 9'h010,
		S_COPY = 9'h020,
		S_FETCH = 9'h040,
		S_PROG = 9'h080,
		S_PWAIT = 9'h100
	} fbr_state_t;
endpackage

// [design/fbr_flash_if.sv]
interface fbr_flash_if;
	import fbr_pkg::*;
	logic re;
	logic we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport ctrl (output re, output we, output addr, output wdata, input rdata);
	modport array (input re, input we, input addr, input wdata, output rdata);
endinterface

// [design/fbr_flash_array.sv]
module fbr_flash_array (
	input wire logic sys_clk_in,
	fbr_flash_if.array fl
);
	import fbr_pkg::*;
	logic [DW-1:0] mem [MEM_WORDS];
	always_ff @(posedge sys_clk_in) begin
		if (fl.we) begin
			mem[fl.addr] <= fl.wdata;
		end
		if (fl.re) begin
			fl.rdata <= mem[fl.addr];
		end
	end
endmodule // fbr_flash_array

// [design/fbr_store.sv]
module fbr_store #(
	parameter int ERASE_TICKS = fbr_pkg::ERASE_OP_TICKS
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic [fbr_pkg::IW-1:0] req_addr_in,
	input wire logic [fbr_pkg::DW-1:0] req_wdata_in,
	output logic req_ready_out,
	output logic rd_valid_out,
	output logic [fbr_pkg::DW-1:0] rd_data_out,
	output logic busy_out
);
	import fbr_pkg::*;
	localparam logic [CW-1:0] ERASE_TICK_LAST = CW'(ERASE_TICKS - 1);
	localparam int SPW = CW + PW;
	localparam logic [SPW-1:0] PROG_SPAN_LAST =
		SPW'(PROG_OP_TICKS * PRESCALE + PROG_BUS_CYCLES - 1);
	localparam logic [SPW-1:0] ERASE_SPAN_LAST = SPW'(ERASE_TICKS * PRESCALE - 1);

	fbr_flash_if fl ();
	fbr_flash_array u_array (.sys_clk_in(sys_clk_in), .fl(fl));

	fbr_state_t state, next_state;
	logic [BW-1:0] scan_bank, cur_bank, dest_bank;
	logic [DW-1:0] best_seq, seq, prog_data;
	logic have_cur;
	logic [IW-1:0] word_idx, wr_addr;
	logic [DW-1:0] wr_data;
	logic [PW-1:0] presc;
	logic [CW-1:0] cnt;
	logic in_bus;
	logic [SW:0] erase_ptr;
	logic [SPW-1:0] span;

	// ----------------------------------------
	// flash op clock prescaler
	// ----------------------------------------
	wire op_tick = (presc == PRESC_ZERO);
	// phase restarts as each operation begins, so every op period counts whole
	wire presc_load = op_tick || (state == S_IDLE) || (state == S_PROG);
	wire timed = (state == S_ERASE) || (state == S_PWAIT);
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			presc <= PRESC_LAST;
		end else begin
			presc <= presc_load ? PRESC_LAST : presc - 1'b1;
		end
	end
	// cycles spent in the current erase or program wait, for the timing checks
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			span <= '0;
		end else begin
			span <= timed ? span + 1'b1 : '0;
		end
	end

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire take = (state == S_IDLE) && req_valid_in;
	wire take_rd = take && !req_write_in;
	wire take_wr = take && req_write_in;
	wire new_sector = (dest_bank[1:0] == FIRST_IN_SECTOR);
	wire is_status = (word_idx == STATUS_IDX);
	wire is_new = (word_idx == wr_addr);
	wire copy_fetch = (state == S_COPY) && !is_status && !is_new && have_cur;
	wire [DW-1:0] next_seq = seq + SEQ_STEP;
	wire status_ok = (fl.rdata != BLANK);
	wire newer = status_ok && (!have_cur || fl.rdata > best_seq);
	wire erase_done = erase_ptr[SW] && op_tick && (cnt == ERASE_TICK_LAST);
	wire prog_done = in_bus && (cnt == PROG_BUS_LAST);
	wire op_active = (state == S_ERASE) || (state == S_PROG) || (state == S_PWAIT);
	wire [BW-1:0] after_cur = {~cur_bank[BW-1], FIRST_IN_SECTOR};

	// array fetch only from states outside program and erase
	assign fl.re = (state == S_SCAN) || take_rd || copy_fetch;
	assign fl.we = ((state == S_ERASE) && !erase_ptr[SW]) || (state == S_PROG);
	assign fl.wdata = (state == S_ERASE) ? BLANK : prog_data;
	assign fl.addr = (state == S_SCAN) ? {scan_bank, STATUS_IDX} :
		(state == S_IDLE) ? {cur_bank, req_addr_in} :
		(state == S_COPY) ? {cur_bank, word_idx} :
		(state == S_ERASE) ? {dest_bank[BW-1], erase_ptr[SW-1:0]} :
		{dest_bank, word_idx};

	// ----------------------------------------
	// state transitions
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			S_SCAN: next_state = S_SCHK;
			S_SCHK: next_state = (scan_bank == LAST_BANK) ? S_IDLE : S_SCAN;
			S_IDLE: begin
				if (take_rd) begin
					next_state = S_RDATA;
				end else if (take_wr) begin
					next_state = new_sector ? S_ERASE : S_COPY;
				end
			end
			S_RDATA: next_state = S_IDLE;
			S_ERASE: next_state = erase_done ? S_COPY : S_ERASE;
			S_COPY: next_state = copy_fetch ? S_FETCH : S_PROG;
			S_FETCH: next_state = S_PROG;
			S_PROG: next_state = S_PWAIT;
			S_PWAIT: begin
				if (prog_done) begin
					next_state = is_status ? S_IDLE : S_COPY;
				end
			end
			default: next_state = S_SCAN;
		endcase
	end

	// ----------------------------------------
	// datapath
	// ----------------------------------------
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= S_SCAN;
			scan_bank <= FIRST_BANK;
			cur_bank <= FIRST_BANK;
			dest_bank <= FIRST_BANK;
			best_seq <= SEQ_ZERO;
			seq <= SEQ_ZERO;
			have_cur <= 1'b0;
			word_idx <= FIRST_IDX;
			wr_addr <= FIRST_IDX;
			wr_data <= BLANK;
			prog_data <= BLANK;
			cnt <= CNT_ZERO;
			in_bus <= 1'b0;
			erase_ptr <= '0;
		end else begin
			state <= next_state;
			case (state)
				S_SCHK: begin
					if (newer) begin
						have_cur <= 1'b1;
						cur_bank <= scan_bank;
						best_seq <= fl.rdata;
						seq <= fl.rdata;
					end
					scan_bank <= scan_bank + 1'b1;
					if (scan_bank == LAST_BANK) begin
						// skip to a fresh sector so partial banks get erased
						if (newer) begin
							dest_bank <= {~scan_bank[BW-1], FIRST_IN_SECTOR};
						end else if (have_cur) begin
							dest_bank <= after_cur;
						end else begin
							dest_bank <= FIRST_BANK;
						end
					end
				end
				S_IDLE: begin
					wr_addr <= req_addr_in;
					wr_data <= req_wdata_in;
					word_idx <= FIRST_IDX;
					cnt <= CNT_ZERO;
					erase_ptr <= '0;
				end
				S_ERASE: begin
					if (!erase_ptr[SW]) begin
						erase_ptr <= erase_ptr + 1'b1;
					end
					if (op_tick) begin
						cnt <= cnt + CNT_STEP;
					end
				end
				S_COPY: begin
					prog_data <= is_status ? next_seq :
						is_new ? wr_data : BLANK;
				end
				S_FETCH: prog_data <= fl.rdata;
				S_PROG: begin
					cnt <= CNT_ZERO;
					in_bus <= 1'b0;
				end
				S_PWAIT: begin
					if (!in_bus && op_tick) begin
						cnt <= (cnt == PROG_TICK_LAST) ? CNT_ZERO : cnt + CNT_STEP;
						in_bus <= (cnt == PROG_TICK_LAST);
					end else if (in_bus) begin
						cnt <= cnt + CNT_STEP;
					end
					if (prog_done) begin
						word_idx <= word_idx + 1'b1;
						if (is_status) begin
							have_cur <= 1'b1;
							cur_bank <= dest_bank;
							dest_bank <= dest_bank + 1'b1;
							seq <= next_seq;
						end
					end
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// host outputs
	// ----------------------------------------
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			req_ready_out <= 1'b0;
			rd_valid_out <= 1'b0;
			rd_data_out <= BLANK;
			busy_out <= 1'b1;
		end else begin
			req_ready_out <= (next_state == S_IDLE);
			busy_out <= (next_state != S_IDLE) && (next_state != S_RDATA);
			rd_valid_out <= (state == S_RDATA);
			if (state == S_RDATA) begin
				rd_data_out <= have_cur ? fl.rdata : BLANK;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_ready_not_busy: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		req_ready_out |-> !busy_out) else $error("ready while update busy");
	a_read_after_rq: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		take_rd |=> ##1 (rd_valid_out && req_ready_out)) else $error("read answer late");
	a_no_fetch_op: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		op_active |-> !fl.re) else $error("fetch during flash operation");
	a_prog_once: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(state == S_PROG) |=> (state == S_PWAIT) && !fl.we) else $error("word written twice");
	a_prog_len: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(state == S_PWAIT && prog_done) |-> span == PROG_SPAN_LAST)
		else $error("program time wrong");
	a_erase_len: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(state == S_ERASE && erase_done) |-> span == ERASE_SPAN_LAST && erase_ptr[SW])
		else $error("erase time wrong");
	a_erase_first: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		$rose(state == S_ERASE) |-> word_idx == FIRST_IDX && dest_bank[1:0] == FIRST_IN_SECTOR)
		else $error("erase not at sector start");
	a_status_last: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(state == S_PROG && is_status) |-> fl.wdata == next_seq && fl.wdata != BLANK)
		else $error("bad status word");
	a_prescale_gap: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		op_tick |=> !op_tick [*8]) else $error("op clock too fast");
endmodule // fbr_store

// [tb/fbr_host_model.sv]
module fbr_host_model (
	input wire logic sys_clk_in,
	input wire logic req_ready_in,
	input wire logic rd_valid_in,
	input wire logic [fbr_pkg::DW-1:0] rd_data_in,
	output logic req_valid_out,
	output logic req_write_out,
	output logic [fbr_pkg::IW-1:0] req_addr_out,
	output logic [fbr_pkg::DW-1:0] req_wdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import fbr_pkg::*;
	// ----------------------------------------
	// request driver
	// ----------------------------------------
	initial begin
		req_valid_out = 1'b0;
		req_write_out = 1'b0;
		req_addr_out = 6'h00;
		req_wdata_out = 16'h0000;
	end
	// holds the request until taken, then collects read data
	task automatic access(input logic wr, input logic [IW-1:0] a, input logic [DW-1:0] d,
		output logic [DW-1:0] q, output logic ok);
		int n;
		ok = 1'b0;
		q = 16'h0000;
		@(posedge sys_clk_in);
		req_valid_out <= 1'b1;
		req_write_out <= wr;
		req_addr_out <= a;
		req_wdata_out <= d;
		n = 0;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (req_ready_in !== 1'b1 && n < 100000);
		req_valid_out <= 1'b0;
		req_write_out <= ~wr;
		req_addr_out <= ~a;
		req_wdata_out <= ~d;
		if (req_ready_in !== 1'b1)
			return;
		if (!wr) begin
			n = 0;
			do begin
				@(posedge sys_clk_in);
				n++;
			end while (rd_valid_in !== 1'b1 && n < 4);
			if (rd_valid_in !== 1'b1)
				return;
			q = rd_data_in;
		end
		ok = 1'b1;
	endtask
endmodule // fbr_host_model

// [tb/fbr_store_tb_top.sv]
module fbr_store_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fbr_pkg::*;
	// ----------------------------------------
	// clock, reset, wiring
	// ----------------------------------------
	localparam int MIN_UPD = BANK_WORDS * (PROG_OP_TICKS * PRESCALE + PROG_BUS_CYCLES);
	localparam int SIM_ERASE = 20;
	typedef struct {logic wr; logic [IW-1:0] a; logic [DW-1:0] d;} fbr_row_t;
	fbr_row_t rows [2] = '{'{1'b1, 6'h05, 16'hA55A}, '{1'b0, 6'h05, 16'hA55A}};
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic req_valid, req_write, req_ready, rd_valid, busy, ok;
	logic [IW-1:0] req_addr;
	logic [DW-1:0] req_wdata, rd_data, q;
	int n_fail = 0;
	int cmp_count = 0;
	int busy_len = 0;
	always #20 sys_clk = ~sys_clk;
	fbr_store #(.ERASE_TICKS(SIM_ERASE)) dut (.sys_clk_in(sys_clk), .rstn_in(rstn),
		.req_valid_in(req_valid), .req_write_in(req_write), .req_addr_in(req_addr),
		.req_wdata_in(req_wdata), .req_ready_out(req_ready), .rd_valid_out(rd_valid),
		.rd_data_out(rd_data), .busy_out(busy));
	fbr_host_model host (.sys_clk_in(sys_clk), .req_ready_in(req_ready),
		.rd_valid_in(rd_valid), .rd_data_in(rd_data), .req_valid_out(req_valid),
		.req_write_out(req_write), .req_addr_out(req_addr), .req_wdata_out(req_wdata));
	// ----------------------------------------
	// compare and report
	// ----------------------------------------
	task automatic check_bit(string nm, logic e, logic g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic check_word(string nm, logic [DW-1:0] e, logic [DW-1:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic check_min(string nm, int lo, int g);
		cmp_count++;
		if (g < lo) begin
			n_fail++;
			$display("ERROR %s expected at least %0d seen %0d", nm, lo, g);
		end
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 100) begin
			@(negedge sys_clk);
			n++;
		end
		check_bit("ready_up", 1'b1, req_ready);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------------------------------------
	// monitors and watchdog
	// ----------------------------------------
	always @(posedge sys_clk) if (busy === 1'b1) busy_len <= busy_len + 1;
	always @(negedge sys_clk) if (rstn === 1'b1 && busy === 1'b1)
		check_bit("rd_valid_busy", 1'b0, rd_valid);
	initial begin
		repeat (MIN_UPD + SIM_ERASE * PRESCALE + 10000) @(posedge sys_clk);
		n_fail++;
		finish_test();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (3) @(negedge sys_clk);
		check_bit("ready_rst", 1'b0, req_ready);
		check_bit("busy_rst", 1'b1, busy);
		check_word("rd_data_rst", BLANK, rd_data);
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		wait_ready();
		check_bit("busy_idle", 1'b0, busy);
		busy_len = 0;
		// write row, then a read held off while the update runs
		foreach (rows[i]) begin
			host.access(rows[i].wr, rows[i].a, rows[i].d, q, ok);
			check_bit("taken", 1'b1, ok);
			if (!rows[i].wr)
				check_word("rd_data", rows[i].d, q);
		end
		check_min("update_cycles", MIN_UPD + SIM_ERASE * PRESCALE, busy_len);
		// second reset: stored value must survive
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (5) @(posedge sys_clk);
		check_bit("ready_rst2", 1'b0, req_ready);
		check_bit("busy_rst2", 1'b1, busy);
		rstn <= 1'b1;
		@(negedge sys_clk);
		wait_ready();
		host.access(1'b0, 6'h05, 16'h0000, q, ok);
		check_word("rd_after_rst", 16'hA55A, q);
		finish_test();
	end
endmodule // fbr_store_tb_top
